// *** hw/reset_release_sequencer.sv ***
// Reset release sequencer with clock start-up tracking and an AHB-Lite register slave.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_release_sequencer #(
    parameter int POR_CYC      = reset_seq_pkg::POR_CYCLES,
    parameter int PWRT_CYC     = reset_seq_pkg::PWRT_CYCLES,
    parameter int PWRT_REG_CYC = reset_seq_pkg::PWRT_REG_CYC,
    parameter int RST_CYC      = reset_seq_pkg::RST_CYCLES,
    parameter int FAST_CYC     = reset_seq_pkg::FAST_CYCLES,
    parameter int SLOW_CYC     = reset_seq_pkg::SLOW_CYCLES,
    parameter int LOCK_CYC     = reset_seq_pkg::LOCK_CYCLES,
    parameter int XTAL_COUNT   = reset_seq_pkg::XTAL_PERIODS
) (
    // Clock and reset.
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // AHB-Lite slave.
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    // Reset sources, configuration pins and the oscillator tick.
    input  wire reset_seq_pkg::rst_src_t   rst_src,
    input  wire reset_seq_pkg::cfg_t       cfg,
    input  wire logic                      osc_tick,
    // Sequencer outputs.
    output logic                           system_reset_out,
    output logic                           clock_released,
    output logic                           cpu_run,
    output logic [3:0]                     active_clock_source,
    output logic                           irq
);

    // Parameters the counters cannot serve are refused at elaboration.
    if (POR_CYC < 1 || PWRT_CYC < 1 || PWRT_REG_CYC < 1 || RST_CYC < 1 ||
        FAST_CYC < 1 || SLOW_CYC < 1 || LOCK_CYC < 1 ||
        XTAL_COUNT < 2 || XTAL_COUNT > 1024) begin : g_bad_param
        $error("reset_release_sequencer: unsupported delay parameter");
    end

    typedef enum logic [2:0] {
        S_HOLD = 3'b000,
        S_POR  = 3'b001,
        S_PWRT = 3'b010,
        S_RST  = 3'b011,
        S_RUN  = 3'b100
    } seq_state_t;

    typedef enum logic [1:0] {
        C_RC    = 2'b00,
        C_XTAL  = 2'b01,
        C_LOCK  = 2'b10,
        C_READY = 2'b11
    } clk_state_t;

    localparam int PIN_W = $bits(reset_seq_pkg::rst_src_t) + $bits(reset_seq_pkg::cfg_t) + 1;

    // Pin synchronisers and state.
    logic [PIN_W-1:0]        pin_meta;
    logic [PIN_W-1:0]        pin_sync;
    logic                    tick_prev;
    reset_seq_pkg::rst_src_t src_s;
    reset_seq_pkg::cfg_t     cfg_s;
    logic                    tick_s;
    logic                    tick_edge;
    logic                    any_src;
    seq_state_t              seq_state;
    clk_state_t              clk_state;
    logic [31:0]             seq_cnt;
    logic [31:0]             clk_cnt;
    logic [9:0]              xtal_cnt;
    logic [1:0]              hold_cnt;
    reset_seq_pkg::rst_src_t held_src;
    logic                    held_swr;
    logic                    need_xtal;
    logic                    need_lock;
    logic                    use_slow;
    logic                    hold_done;
    logic                    release_now;
    logic                    clk_done;
    logic                    fail_switch;
    logic [31:0]             seq_term;
    logic [31:0]             rc_term;
    logic [3:0]              launch_src;
    logic [3:0]              launch_flags;
    // Register file and bus.
    logic                    sw_reset;
    logic [2:0]              int_status;
    logic [2:0]              int_mask;
    logic [15:0]             cause;
    logic [15:0]             calib;
    logic [15:0]             nvm_ctrl;
    logic [3:0]              cur_src;
    logic                    wr_pend;
    logic                    rd_pend;
    logic [7:0]              wr_addr;
    logic [7:0]              rd_addr;
    logic                    wr_commit;
    logic [31:0]             rd_value;

    // Source classification: {fast rc wait, low-power rc wait, crystal count, pll lock}.
    function automatic logic [3:0] src_flags(input logic [3:0] src);
        case (src)
            reset_seq_pkg::SRC_FAST,
            reset_seq_pkg::SRC_FRCDIV: src_flags = 4'b1000;
            reset_seq_pkg::SRC_SLOW:   src_flags = 4'b0100;
            reset_seq_pkg::SRC_ECPLL:  src_flags = 4'b0001;
            reset_seq_pkg::SRC_FRCPLL: src_flags = 4'b1001;
            reset_seq_pkg::SRC_XT,
            reset_seq_pkg::SRC_HS,
            reset_seq_pkg::SRC_SEC:    src_flags = 4'b0010;
            reset_seq_pkg::SRC_XTPLL,
            reset_seq_pkg::SRC_HSPLL:  src_flags = 4'b0011;
            default:                   src_flags = 4'b0000;
        endcase
    endfunction : src_flags

    // First clock phase for a set of flags.
    function automatic clk_state_t first_phase(input logic [3:0] f);
        if (f[3] || f[2]) begin
            first_phase = C_RC;
        end else if (f[1]) begin
            first_phase = C_XTAL;
        end else if (f[0]) begin
            first_phase = C_LOCK;
        end else begin
            first_phase = C_READY;
        end
    endfunction : first_phase

    // Two flip-flops on every pin before any logic reads it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta  <= '0;
            pin_sync  <= '0;
            tick_prev <= 1'b0;
        end else begin
            pin_meta  <= {rst_src, cfg, osc_tick};
            pin_sync  <= pin_meta;
            tick_prev <= pin_sync[0];
        end
    end

    // Decoded synchronised pins and sequencing terms.
    always_comb begin
        {src_s, cfg_s, tick_s} = pin_sync;
        tick_edge   = tick_s && !tick_prev;
        any_src     = (|src_s) || sw_reset; // R16
        hold_done   = (seq_state == S_HOLD) && !any_src &&
                      (hold_cnt == 2'(reset_seq_pkg::HOLD_MIN - 1));
        // Two-speed start-up begins on the fast RC whatever source is selected.
        launch_src  = cfg_s.two_speed ? reset_seq_pkg::SRC_FAST :
                      cfg_s.initial_oscillator_select; // R7
        launch_flags = src_flags(launch_src);
        case (seq_state)
            S_POR:   seq_term = 32'(POR_CYC);
            S_PWRT:  seq_term = cfg_s.regulator_enable_pin ? 32'(PWRT_REG_CYC) :
                                                             32'(PWRT_CYC); // R2
            S_RST:   seq_term = 32'(RST_CYC);
            default: seq_term = 32'h0000_0001;
        endcase
        release_now = (seq_state == S_RST) && (seq_cnt == seq_term - 32'h0000_0001); // R18
        rc_term     = use_slow ? 32'(SLOW_CYC) : 32'(FAST_CYC);
        case (clk_state)
            C_RC:    clk_done = (clk_cnt == rc_term - 32'h0000_0001); // R4
            C_XTAL:  clk_done = tick_edge && (xtal_cnt == 10'(XTAL_COUNT - 1)); // R6
            C_LOCK:  clk_done = (clk_cnt == 32'(LOCK_CYC) - 32'h0000_0001); // R5
            default: clk_done = 1'b0;
        endcase
        // The monitor looks at the clock on the last cycle of the state reset delay, two cycles before system_reset_out falls.
        fail_switch = release_now && cfg_s.monitor_en && (clk_state != C_READY); // R10
    end

    // System reset delay chain.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_state <= S_HOLD;
            seq_cnt   <= '0;
            hold_cnt  <= '0;
            held_src  <= '{por: 1'b1, default: 1'b0};
            held_swr  <= 1'b0;
        end else if (any_src) begin
            seq_state <= S_HOLD; // R16
            seq_cnt   <= '0;
            hold_cnt  <= '0;
            held_src  <= (seq_state == S_HOLD) ? (held_src | src_s) : src_s;
            held_swr  <= (seq_state == S_HOLD) ? (held_swr | sw_reset) : sw_reset;
        end else begin
            case (seq_state)
                S_HOLD: begin
                    hold_cnt <= hold_cnt + 2'b01;
                    if (hold_done) begin
                        if (held_src.por) begin
                            seq_state <= S_POR; // R1
                        end else if (held_src.bor) begin
                            seq_state <= S_PWRT;
                        end else begin
                            seq_state <= S_RST; // R3
                        end
                    end
                end
                S_POR, S_PWRT, S_RST: begin
                    if (seq_cnt == seq_term - 32'h0000_0001) begin
                        seq_cnt   <= '0;
                        seq_state <= (seq_state == S_POR) ? S_PWRT :
                                     (seq_state == S_PWRT) ? S_RST : S_RUN; // R18
                    end else begin
                        seq_cnt <= seq_cnt + 32'h0000_0001;
                    end
                end
                S_RUN:   seq_cnt <= '0;
                default: seq_state <= S_HOLD;
            endcase
        end
    end

    // Clock start-up phases, launched with the reset delay and run beside it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_state <= C_READY;
            clk_cnt   <= '0;
            xtal_cnt  <= '0;
            need_xtal <= 1'b0;
            need_lock <= 1'b0;
            use_slow  <= 1'b0;
            cur_src   <= reset_seq_pkg::SRC_FAST;
        end else if (hold_done) begin
            clk_cnt  <= '0; // R17
            xtal_cnt <= '0;
            if (held_src.por || held_src.bor) begin
                clk_state <= first_phase(launch_flags); // R8
                need_xtal <= launch_flags[1];
                need_lock <= launch_flags[0];
                use_slow  <= launch_flags[2];
                cur_src   <= launch_src; // R14
            end else begin
                clk_state <= C_READY; // R3
            end
        end else if (fail_switch) begin
            clk_state <= C_RC; // R11
            clk_cnt   <= '0;
            need_xtal <= 1'b0;
            need_lock <= 1'b0;
            use_slow  <= 1'b0;
            cur_src   <= reset_seq_pkg::SRC_FAST; // R11
        end else begin
            case (clk_state)
                C_RC, C_LOCK: clk_cnt <= clk_done ? '0 : clk_cnt + 32'h0000_0001;
                C_XTAL: begin
                    if (tick_edge) begin
                        xtal_cnt <= xtal_cnt + 10'h001;
                    end
                end
                C_READY: clk_cnt <= '0;
                default: clk_cnt <= '0;
            endcase
            if (clk_done) begin
                if (clk_state == C_RC && need_xtal) begin
                    clk_state <= C_XTAL;
                end else if (clk_state != C_LOCK && need_lock) begin
                    clk_state <= C_LOCK; // R5
                end else begin
                    clk_state <= C_READY;
                end
            end
        end
    end

    // Registered outputs of the sequencer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_reset_out    <= 1'b1;
            clock_released      <= 1'b0;
            cpu_run             <= 1'b0;
            active_clock_source <= reset_seq_pkg::SRC_FAST;
            irq                 <= 1'b0;
        end else begin
            system_reset_out    <= (seq_state != S_RUN) || any_src; // R16
            clock_released      <= (clk_state == C_READY);
            cpu_run             <= (seq_state == S_RUN) && (clk_state == C_READY) &&
                                   !any_src; // R9
            active_clock_source <= cur_src;
            irq                 <= |(int_status & int_mask);
        end
    end

    // Bus request capture: writes commit in their data phase, reads take one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            wr_addr   <= '0;
            rd_addr   <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend) begin
                rd_pend   <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= rd_value;
            end else if (hready) begin
                wr_pend <= hsel && htrans[1] && hwrite;
                wr_addr <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    rd_pend   <= 1'b1;
                    rd_addr   <= haddr[7:0];
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    assign wr_commit = wr_pend && hready;

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_value = '0;
        case (rd_addr)
            reset_seq_pkg::OFS_CTRL:       rd_value = {31'h0, sw_reset};
            reset_seq_pkg::OFS_STATUS:     rd_value = {24'h0, cur_src, seq_state == S_RUN,
                                                       clk_state == C_READY, clk_state};
            reset_seq_pkg::OFS_INT_STATUS: rd_value = {29'h0, int_status};
            reset_seq_pkg::OFS_INT_MASK:   rd_value = {29'h0, int_mask};
            reset_seq_pkg::OFS_CAUSE:      rd_value = {16'h0, cause};
            reset_seq_pkg::OFS_OSC_CTRL:   rd_value = 32'(cur_src) <<
                                                      reset_seq_pkg::OSC_CUR_LSB;
            reset_seq_pkg::OFS_CALIB:      rd_value = {16'h0, calib};
            reset_seq_pkg::OFS_NVM_CTRL:   rd_value = {16'h0, nvm_ctrl};
            default:                       rd_value = '0;
        endcase
    end

    // Control, interrupt status and mask take one value on every reset kind.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_reset   <= 1'b0;
            int_status <= '0;
            int_mask   <= '0;
        end else if (any_src) begin
            sw_reset   <= 1'b0; // R12
            int_status <= '0;
            int_mask   <= '0;
        end else begin
            sw_reset <= wr_commit && (wr_addr == reset_seq_pkg::OFS_CTRL) &&
                        hwdata[reset_seq_pkg::CTRL_SW_RESET];
            if (wr_commit && wr_addr == reset_seq_pkg::OFS_INT_MASK) begin
                int_mask <= hwdata[2:0];
            end
            // Events set after the write-one clear, so a coincident event survives.
            int_status <= (int_status &
                           ~((wr_commit && wr_addr == reset_seq_pkg::OFS_INT_STATUS) ?
                             hwdata[2:0] : 3'h0)) |
                          {fail_switch, clk_done && clk_state != C_READY &&
                           (clk_state == C_LOCK || !(need_lock ||
                           (clk_state == C_RC && need_xtal))), release_now};
        end
    end

    // Reset cause flags: power-on clears all and sets two; other kinds add theirs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause <= reset_seq_pkg::CAUSE_POR_VALUE;
        end else if (hold_done) begin
            if (held_src.por) begin
                cause <= reset_seq_pkg::CAUSE_POR_VALUE; // R13
            end else begin
                cause[reset_seq_pkg::CAUSE_BOR]     <= cause[reset_seq_pkg::CAUSE_BOR] |
                                                       held_src.bor; // R13
                cause[reset_seq_pkg::CAUSE_EXT]     <= cause[reset_seq_pkg::CAUSE_EXT] |
                                                       held_src.mclr;
                cause[reset_seq_pkg::CAUSE_WDT]     <= cause[reset_seq_pkg::CAUSE_WDT] |
                                                       held_src.wdt;
                cause[reset_seq_pkg::CAUSE_SWR]     <= cause[reset_seq_pkg::CAUSE_SWR] |
                                                       held_swr;
                cause[reset_seq_pkg::CAUSE_CM]      <= cause[reset_seq_pkg::CAUSE_CM] |
                                                       held_src.mismatch;
                cause[reset_seq_pkg::CAUSE_ILLEGAL] <= cause[reset_seq_pkg::CAUSE_ILLEGAL] |
                                                       held_src.illegal;
                cause[reset_seq_pkg::CAUSE_TRAP]    <= cause[reset_seq_pkg::CAUSE_TRAP] |
                                                       held_src.trap;
            end
        end else if (wr_commit && wr_addr == reset_seq_pkg::OFS_CAUSE) begin
            cause <= hwdata[15:0];
        end
    end

    // Calibration and memory control survive every reset but power-on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            calib    <= '0;
            nvm_ctrl <= '0;
        end else if (hold_done && held_src.por) begin
            calib    <= '0; // R15
            nvm_ctrl <= '0;
        end else if (wr_commit) begin
            if (wr_addr == reset_seq_pkg::OFS_CALIB) begin
                calib <= hwdata[15:0];
            end
            if (wr_addr == reset_seq_pkg::OFS_NVM_CTRL) begin
                nvm_ctrl <= hwdata[15:0];
            end
        end
    end

endmodule : reset_release_sequencer
`default_nettype wire

// *** pkg/reset_seq_pkg.sv ***
// Constants, types and register map of the reset release sequencer.
// Operation
// R1: Power-on reset holds system reset through power-on, power-up and state delays.
// R2: Power-up delay is 64 ms while the on-chip regulator is disabled.
// R3: Resets other than power-on and brown-out use only the state reset delay.
// R4: RC clock sources after power-on or brown-out wait their oscillator start-up time.
// R5: PLL clock sources after power-on or brown-out also wait the PLL lock time.
// R6: Crystal and secondary sources count 1024 oscillator periods before clock release.
// R7: Two-speed start-up runs from the fast RC first, with its start-up time.
// R8: Clock start-up timing runs apart from reset delays; clock may lag reset release.
// R9: Processor runs only once reset is released and a valid clock is released.
// R10: Clock fail monitor checks the clock at the moment system reset releases.
// R11: No valid clock at release switches the system clock to the fast RC.
// R12: Registers take one reset value for every reset type, four excepted.
// R13: Reset cause register reset value depends on the reset kind.
// R14: Oscillator control reset value follows reset kind and initial oscillator select.
// R15: Calibration and memory control registers reset only on power-on reset.
// R16: Any active reset source asserts system reset and resets block registers.
// R17: Clock start-up and PLL lock run concurrently with the system reset delay.
// R18: Each delay phase is a parameterised counter, advancing only on terminal count.
package reset_seq_pkg;

    // Clock rate and delay times in their own units.
    localparam int CLK_KHZ       = 40000;
    localparam int PWRT_MS       = 64;
    localparam int PWRT_REG_US   = 10;
    localparam int POR_US        = 10;
    localparam int RST_US        = 10;
    localparam int FAST_US       = 15;
    localparam int SLOW_US       = 100;
    localparam int LOCK_US       = 100;
    localparam int PWRT_CYCLES   = PWRT_MS * CLK_KHZ;
    localparam int PWRT_REG_CYC  = (PWRT_REG_US * CLK_KHZ + 999) / 1000;
    localparam int POR_CYCLES    = (POR_US * CLK_KHZ + 999) / 1000;
    localparam int RST_CYCLES    = (RST_US * CLK_KHZ + 999) / 1000;
    localparam int FAST_CYCLES   = (FAST_US * CLK_KHZ + 999) / 1000;
    localparam int SLOW_CYCLES   = (SLOW_US * CLK_KHZ + 999) / 1000;
    localparam int LOCK_CYCLES   = (LOCK_US * CLK_KHZ + 999) / 1000;
    localparam int XTAL_PERIODS  = 1024;
    localparam int HOLD_MIN      = 3;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_MASK   = 8'h0C;
    localparam logic [7:0] OFS_CAUSE      = 8'h10;
    localparam logic [7:0] OFS_OSC_CTRL   = 8'h14;
    localparam logic [7:0] OFS_CALIB      = 8'h18;
    localparam logic [7:0] OFS_NVM_CTRL   = 8'h1C;

    // Field positions and the power-on cause value.
    localparam int CTRL_SW_RESET  = 0;
    localparam int EV_RELEASED    = 0;
    localparam int EV_CLOCK_READY = 1;
    localparam int EV_CLOCK_FAIL  = 2;
    localparam int CAUSE_POR      = 0;
    localparam int CAUSE_BOR      = 1;
    localparam int CAUSE_WDT      = 4;
    localparam int CAUSE_SWR      = 6;
    localparam int CAUSE_EXT      = 7;
    localparam int CAUSE_CM       = 9;
    localparam int CAUSE_ILLEGAL  = 14;
    localparam int CAUSE_TRAP     = 15;
    localparam int OSC_CUR_LSB    = 12;
    localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;

    // Clock sources.
    typedef enum logic [3:0] {
        SRC_EC     = 4'h0,
        SRC_FAST   = 4'h1,
        SRC_FRCDIV = 4'h2,
        SRC_SLOW   = 4'h3,
        SRC_ECPLL  = 4'h4,
        SRC_FRCPLL = 4'h5,
        SRC_XT     = 4'h6,
        SRC_HS     = 4'h7,
        SRC_SEC    = 4'h8,
        SRC_XTPLL  = 4'h9,
        SRC_HSPLL  = 4'hA
    } clk_src_t;

    // Reset source pins.
    typedef struct packed {
        logic por;
        logic bor;
        logic mclr;
        logic wdt;
        logic trap;
        logic illegal;
        logic mismatch;
    } rst_src_t;

    // Configuration pins.
    typedef struct packed {
        logic       regulator_enable_pin;
        logic       two_speed;
        logic       monitor_en;
        logic [3:0] initial_oscillator_select;
    } cfg_t;

endpackage : reset_seq_pkg

// *** testbench/osc_model.sv ***
// Free-running oscillator model feeding the oscillator tick input.
`timescale 1ns/1ps
`default_nettype none
module osc_model #(parameter int HALF = 2) (
    // Time base and oscillator level.
    input  wire logic hclk,
    output var  logic osc_tick = 1'b0
);
    int cnt = 0;
    // Toggles every HALF bus cycles, so the tick stays slower than half the bus clock.
    always @(posedge hclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) osc_tick <= ~osc_tick;
    end
endmodule : osc_model
`default_nettype wire

// *** testbench/reset_release_sequencer_asserts.sv ***
// Concurrent checks on the reset release sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module reset_release_sequencer_asserts (
    // Watched ports.
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, irq,
    input wire logic system_reset_out, clock_released, cpu_run,
    input wire logic [1:0] htrans,
    input wire logic [3:0] active_clock_source,
    input wire reset_seq_pkg::rst_src_t rst_src,
    input wire reset_seq_pkg::cfg_t cfg
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Request decode shared by the bus checks.
    wire logic req = hsel && htrans[1] && hready;
    AST_READ: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WRITE: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
    AST_RUN: assert property (cpu_run |-> !system_reset_out && clock_released)
        else $error("cpu runs without reset release and clock");
    AST_SRC: assert property ((rst_src != 0) [*3] |=> system_reset_out)
        else $error("active source left reset released");
    AST_HOLD: assert property ($fell(system_reset_out) |-> $past(system_reset_out, 8))
        else $error("reset released before its delay");
    AST_GO: assert property ((!system_reset_out && clock_released && rst_src == 0) [*3]
        |-> ##[0:2] cpu_run) else $error("cpu not started");
    AST_FAIL: assert property ($fell(system_reset_out) && cfg.monitor_en && !clock_released
        |-> ##[0:3] active_clock_source == reset_seq_pkg::SRC_FAST)
        else $error("no switch to fast rc");
    AST_KEEP: assert property ($rose(system_reset_out) && clock_released && !rst_src.por
        && !rst_src.bor |=> clock_released [*3]) else $error("clock lost");
    // Main scenarios.
    cover property ($fell(system_reset_out));
    cover property (req && !hwrite);
    cover property ($rose(irq));
endmodule : reset_release_sequencer_asserts
bind reset_release_sequencer reset_release_sequencer_asserts u_chk (.hclk, .hresetn,
    .hsel, .hwrite, .hready, .hreadyout, .irq, .system_reset_out, .clock_released,
    .cpu_run, .htrans, .active_clock_source, .rst_src, .cfg);
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench of the reset release sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    reset_seq_pkg::rst_src_t rst_src = '0;
    reset_seq_pkg::cfg_t cfg = 7'h16;
    wire logic hreadyout, hresp, system_reset_out, clock_released, cpu_run, irq, osc_tick;
    wire logic [31:0] hrdata;
    wire logic [3:0] active_clock_source;
    int error_cnt = 0, checks = 0, n;
    // Bus clock of 25 ns.
    always #12.5 hclk = ~hclk;
    osc_model u_osc (.hclk, .osc_tick);
    reset_release_sequencer #(.POR_CYC(8), .PWRT_CYC(50), .PWRT_REG_CYC(8), .RST_CYC(8),
        .FAST_CYC(10), .SLOW_CYC(100), .LOCK_CYC(10), .XTAL_COUNT(4)) DUT (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .rst_src, .cfg, .osc_tick, .system_reset_out,
        .clock_released, .cpu_run, .active_clock_source, .irq);
    task chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    // One single AHB-Lite transfer; read data lands in rd.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 0);
    endtask : bus
    // Counts cycles until system reset drops and checks the span.
    task rel(input int lo, hi);
        n = 0;
        while (system_reset_out !== 1'b0 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
    endtask : rel
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Watchdog against a hang.
    initial begin
        repeat (5000) @(posedge hclk);
        error_cnt++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rel(66, 76);
        bus(0, 8'h10, 0); chk(rd, 32'h3);
        bus(0, 8'h14, 0); chk(rd[15:12], 4'h6);
        bus(1, 8'h0C, 32'h1); repeat (2) @(posedge hclk); chk(irq, 1);
        bus(1, 8'h08, 32'h7); repeat (2) @(posedge hclk); chk(irq, 0);
        bus(1, 8'h18, 32'hA5A5); bus(0, 8'h20, 0); chk(rd, 0);
        $display("power-on test done");
        rst_src.mclr <= 1'b1; repeat (5) @(posedge hclk); rst_src.mclr <= 1'b0;
        rel(10, 18); chk(clock_released, 1);
        bus(0, 8'h18, 0); chk(rd, 32'hA5A5);
        bus(0, 8'h10, 0); chk(rd, 32'h83);
        $display("pin reset test done");
        cfg <= 7'h53; hresetn <= 1'b0; repeat (2) @(posedge hclk); hresetn <= 1'b1;
        rel(26, 34);
        repeat (3) @(posedge hclk); chk(active_clock_source, 4'h1);
        bus(0, 8'h08, 0); chk(rd[2], 1);
        bus(0, 8'h18, 0); chk(rd, 0);
        repeat (20) @(posedge hclk); chk(cpu_run, 1);
        $display("regulator and monitor test done");
        cfg <= 7'h23; rst_src <= 7'h28; repeat (5) @(posedge hclk); rst_src <= '0;
        rel(60, 70); chk(active_clock_source, 4'h1);
        bus(0, 8'h10, 0); chk(rd, 32'h13);
        bus(1, 8'h00, 32'h1); repeat (2) @(posedge hclk); rel(10, 18);
        bus(0, 8'h10, 0); chk(rd, 32'h53);
        $display("brown-out and software reset test done");
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
